// [logic/pwmg_pkg.sv]
`default_nettype none
package pwmg_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_PIN_REL = 8'hb7;
  localparam logic [7:0] IDX_ENABLE  = 8'hcf;
  localparam logic [7:0] IDX_CTRL    = 8'hd2;
  localparam logic [7:0] IDX_PER_LO  = 8'hd3;
  localparam logic [7:0] IDX_PER_HI  = 8'hd4;
  localparam logic [7:0] IDX_DUTY_LO = 8'hd5;
  localparam logic [7:0] IDX_DUTY_HI = 8'hd6;
  localparam logic [7:0] IDX_LOCK    = 8'he7;
  localparam logic [7:0] IDX_SYSCFG  = 8'hf0;

  // ----------------------------------------------------------------
  // Field positions and keys
  // ----------------------------------------------------------------
  localparam int         EN_OUT_BIT  = 0;
  localparam int         EN_AUX_BIT  = 3;
  localparam int         EN_FILT_BIT = 6;
  localparam int         REL_BIT     = 0;
  localparam int         CTL_IE_BIT  = 7;
  localparam int         CTL_IF_BIT  = 6;
  localparam int         CTL_POL_BIT = 2;
  localparam int         SYS_GIE_BIT = 7;
  localparam logic [7:0] LOCK_KEY    = 8'h55;

  // Oscillator option codes
  localparam logic [3:0] OSC_RC_A = 4'h0;
  localparam logic [3:0] OSC_RC_B = 4'h3;
  localparam logic [3:0] OSC_RC_C = 4'h6;
  localparam logic [3:0] OSC_XTAL = 4'he;

  // ----------------------------------------------------------------
  // Reset values and responses
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [3:0]  RST_OSC   = 4'h0;
  localparam logic [3:0]  RST_PRESC = 4'h0;
  localparam logic [11:0] RST_CNT   = 12'h000;
  localparam logic [1:0]  RESP_OKAY = 2'b00;
  localparam logic [1:0]  RESP_SLV  = 2'b10;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_NONE = 2'b00,
    SRC_RC   = 2'b01,
    SRC_XTAL = 2'b10
  } pwmg_src_t;

  typedef struct packed {
    logic       pol;
    logic [1:0] div;
  } pwmg_ctl_t;

  typedef struct packed {
    logic [11:0] period;
    logic [11:0] duty;
  } pwmg_val_t;

endpackage
`default_nettype wire

// [logic/pwmg_top.sv]
`timescale 1ns/1ns
`default_nettype none
// How it works
// [R1] Output enable bit 1 hands the pin to the modulator, 0 leaves general I/O.
// [R2] Software keeps the two auxiliary enable bits at zero while modulating.
// [R3] Clearing the enable register stops output immediately, mid period.
// [R4] Pin release bit returns pin to I/O; timer and flag keep running.
// [R5] Enable, control, period and duty writes only land while lock holds 55h.
// [R6] Polarity, clock select, period and duty changes while enabled load at next period.
// [R7] Overflow requests interrupt only when local and global enables are set.
// [R8] Overflow sets the flag; only a software write clears it.
// [R9] Polarity 0 drives high during duty, polarity 1 inverts that.
// [R10] Clock select divides oscillator by 2, 4, 8 or 16.
// [R11] Oscillator option code chooses internal RC or crystal tick source.
// [R12] Inactive modulator holds output at polarity level.
// [R13] Period is 12-bit value times modulator clock, low byte plus high nibble.
// [R14] Zero period with polarity 0 keeps output low.
// [R15] Zero period with polarity 1 keeps output high.
// [R16] Duty is 12-bit value times modulator clock, low byte plus high nibble.
// [R17] Period not above duty keeps output active for whole period.
// [R18] Low byte write commits only when the high byte is written after it.
// [R19] Counter advances per modulator tick, wraps at period, wrap is overflow.
// [R20] Lock resets to zero so configuration is protected after reset.
module pwmg_top #(
  parameter int ADDR_W = 12
) (
  // Clock, reset, freeze
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Oscillator ticks
  input  wire logic              rc_osc_tick,
  input  wire logic              xtal_osc_tick,
  // Pin and interrupt
  output logic                   pwm_pin_o,
  output logic                   pwm_pin_sel,
  output logic                   irq_request
);
  import pwmg_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic              aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0]        aw_idx, next_aw_idx, w_byte, next_w_byte;
  logic              w_lane, next_w_lane;
  logic              next_bvalid, next_rvalid;
  logic [1:0]        next_bresp, next_rresp;
  logic [31:0]       next_rdata;
  logic              out_en, next_out_en, aux_en, next_aux_en;
  logic              filt_en, next_filt_en, rel, next_rel;
  logic              ie, next_ie, flag, next_flag, gie, next_gie;
  logic [7:0]        lock, next_lock, per_lo, next_per_lo;
  logic [7:0]        duty_lo, next_duty_lo;
  logic [3:0]        osc_code, next_osc_code;
  pwmg_ctl_t         ctl_w, next_ctl_w, ctl_a, next_ctl_a;
  pwmg_val_t         val_w, next_val_w, val_a, next_val_a;
  logic [3:0]        presc, next_presc, presc_last;
  logic [11:0]       cnt, next_cnt;
  logic              next_pin;
  logic              wr_go, unlocked, osc_tick, mod_tick, wrap, active;
  pwmg_src_t         src;

  function automatic logic [7:0] idx_of(input logic [ADDR_W-1:0] a);
    return a[9:2];
  endfunction

  function automatic logic is_mapped(input logic [7:0] i);
    return i == IDX_PIN_REL || i == IDX_ENABLE || i == IDX_CTRL || i == IDX_PER_LO ||
           i == IDX_PER_HI || i == IDX_DUTY_LO || i == IDX_DUTY_HI || i == IDX_LOCK ||
           i == IDX_SYSCFG;
  endfunction

  // ----------------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------------
  assign awready     = ce & ~aw_held;
  assign wready      = ce & ~w_held;
  assign arready     = ce & ~rvalid;
  assign wr_go       = aw_held & w_held & ~bvalid;
  assign unlocked    = lock == LOCK_KEY;
  assign pwm_pin_sel = out_en & ~rel; // [R1] [R4] pin owner
  // [R7] interrupt gating
  assign irq_request = flag & ie & gie;

  // ----------------------------------------------------------------
  // Registers and bus next state
  // ----------------------------------------------------------------
  always_comb begin
    next_aw_held  = aw_held;
    next_aw_idx   = aw_idx;
    next_w_held   = w_held;
    next_w_byte   = w_byte;
    next_w_lane   = w_lane;
    next_bvalid   = bvalid;
    next_bresp    = bresp;
    next_rvalid   = rvalid;
    next_rdata    = rdata;
    next_rresp    = rresp;
    next_out_en   = out_en;
    next_aux_en   = aux_en;
    next_filt_en  = filt_en;
    next_rel      = rel;
    next_ie       = ie;
    next_flag     = flag;
    next_gie      = gie;
    next_lock     = lock;
    next_per_lo   = per_lo;
    next_duty_lo  = duty_lo;
    next_osc_code = osc_code;
    next_ctl_w    = ctl_w;
    next_val_w    = val_w;
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_idx  = idx_of(awaddr);
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_w_byte = wdata[7:0];
      next_w_lane = wstrb[0];
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (wr_go) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = is_mapped(aw_idx) ? RESP_OKAY : RESP_SLV;
      if (w_lane) begin
        unique case (aw_idx)
          IDX_LOCK:    next_lock = w_byte;
          IDX_PIN_REL: next_rel = w_byte[REL_BIT];
          IDX_SYSCFG: begin
            next_gie      = w_byte[SYS_GIE_BIT];
            next_osc_code = w_byte[3:0];
          end
          default: begin
            // [R5] locked group
            if (unlocked) begin
              unique case (aw_idx)
                IDX_ENABLE: begin
                  next_out_en  = w_byte[EN_OUT_BIT];
                  next_aux_en  = w_byte[EN_AUX_BIT];
                  next_filt_en = w_byte[EN_FILT_BIT];
                end
                IDX_CTRL: begin
                  next_ie      = w_byte[CTL_IE_BIT];
                  next_flag    = flag & w_byte[CTL_IF_BIT];
                  next_ctl_w   = '{pol: w_byte[CTL_POL_BIT], div: w_byte[1:0]};
                end
                IDX_PER_LO:  next_per_lo = w_byte;
                // [R13] [R18] high byte commits
                IDX_PER_HI:  next_val_w.period = {w_byte[3:0], per_lo};
                IDX_DUTY_LO: next_duty_lo = w_byte;
                // [R16] [R18] high byte commits
                IDX_DUTY_HI: next_val_w.duty = {w_byte[3:0], duty_lo};
                default: ;
              endcase
            end
          end
        endcase
      end
    end
    // [R8] set wins over clear
    if (wrap) begin
      next_flag = 1'b1;
    end
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp  = is_mapped(idx_of(araddr)) ? RESP_OKAY : RESP_SLV;
      next_rdata  = 32'h0000_0000;
      unique case (idx_of(araddr))
        IDX_PIN_REL: next_rdata[REL_BIT] = rel;
        IDX_ENABLE: begin
          next_rdata[EN_OUT_BIT]  = out_en;
          next_rdata[EN_AUX_BIT]  = aux_en;
          next_rdata[EN_FILT_BIT] = filt_en;
        end
        IDX_CTRL:    next_rdata[7:0] = {ie, flag, 3'b000, ctl_w.pol, ctl_w.div};
        IDX_PER_LO:  next_rdata[7:0] = per_lo;
        IDX_PER_HI:  next_rdata[3:0] = val_w.period[11:8];
        IDX_DUTY_LO: next_rdata[7:0] = duty_lo;
        IDX_DUTY_HI: next_rdata[3:0] = val_w.duty[11:8];
        IDX_LOCK:    next_rdata[7:0] = lock;
        IDX_SYSCFG:  next_rdata[7:0] = {gie, 3'b000, osc_code};
        default: ;
      endcase
    end
  end

  // Register bank; lock clears on reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held  <= 1'b0;
      aw_idx   <= RST_BYTE;
      w_held   <= 1'b0;
      w_byte   <= RST_BYTE;
      w_lane   <= 1'b0;
      bvalid   <= 1'b0;
      bresp    <= RESP_OKAY;
      rvalid   <= 1'b0;
      rdata    <= 32'h0000_0000;
      rresp    <= RESP_OKAY;
      out_en   <= 1'b0;
      aux_en   <= 1'b0;
      filt_en  <= 1'b0;
      rel      <= 1'b0;
      ie       <= 1'b0;
      flag     <= 1'b0;
      gie      <= 1'b0;
      // [R20] protected after reset
      lock     <= RST_BYTE;
      per_lo   <= RST_BYTE;
      duty_lo  <= RST_BYTE;
      osc_code <= RST_OSC;
      ctl_w    <= '0;
      val_w    <= '0;
    end else if (ce) begin
      aw_held  <= next_aw_held;
      aw_idx   <= next_aw_idx;
      w_held   <= next_w_held;
      w_byte   <= next_w_byte;
      w_lane   <= next_w_lane;
      bvalid   <= next_bvalid;
      bresp    <= next_bresp;
      rvalid   <= next_rvalid;
      rdata    <= next_rdata;
      rresp    <= next_rresp;
      out_en   <= next_out_en;
      aux_en   <= next_aux_en;
      filt_en  <= next_filt_en;
      rel      <= next_rel;
      ie       <= next_ie;
      flag     <= next_flag;
      gie      <= next_gie;
      lock     <= next_lock;
      per_lo   <= next_per_lo;
      duty_lo  <= next_duty_lo;
      osc_code <= next_osc_code;
      ctl_w    <= next_ctl_w;
      val_w    <= next_val_w;
    end
  end

  // ----------------------------------------------------------------
  // Timer and output
  // ----------------------------------------------------------------
  always_comb begin
    // [R11] source select
    unique case (osc_code)
      OSC_RC_A, OSC_RC_B, OSC_RC_C: src = SRC_RC;
      OSC_XTAL:                     src = SRC_XTAL;
      default:                      src = SRC_NONE;
    endcase
    unique case (src)
      SRC_RC:   osc_tick = rc_osc_tick;
      SRC_XTAL: osc_tick = xtal_osc_tick;
      default:  osc_tick = 1'b0;
    endcase
    // [R10] divide by 2, 4, 8, 16
    presc_last = 4'((5'd2 << ctl_a.div) - 5'd1);
    mod_tick   = out_en & osc_tick & (presc == presc_last);
    next_presc = presc;
    if (!out_en) begin
      next_presc = RST_PRESC;
    end else if (osc_tick) begin
      next_presc = (presc == presc_last) ? RST_PRESC : 4'(presc + 4'h1);
    end
    // [R19] count and wrap
    wrap     = mod_tick & (val_a.period != 12'h000) & (cnt == 12'(val_a.period - 12'h001));
    next_cnt = cnt;
    if (!out_en || wrap) begin
      next_cnt = RST_CNT; // [R3] disable resets at once
    end else if (mod_tick && val_a.period != 12'h000) begin
      next_cnt = 12'(cnt + 12'h001);
    end
    // [R6] shadow loads at period start
    next_ctl_a = ctl_a;
    next_val_a = val_a;
    if (!out_en || wrap) begin
      next_ctl_a = ctl_w;
      next_val_a = val_w;
    end
    // [R14] [R15] [R17] active window
    active = (val_a.period != 12'h000) & (cnt < val_a.duty);
    // [R9] [R12] polarity and idle level
    next_pin = out_en ? (active ^ ctl_a.pol) : ctl_a.pol;
  end

  // Timer registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc     <= RST_PRESC;
      cnt       <= RST_CNT;
      ctl_a     <= '0;
      val_a     <= '0;
      pwm_pin_o <= 1'b0;
    end else if (ce) begin
      presc     <= next_presc;
      cnt       <= next_cnt;
      ctl_a     <= next_ctl_a;
      val_a     <= next_val_a;
      pwm_pin_o <= next_pin;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  lock_gate_a: assert property ( // [R5]
    ce && wr_go && w_lane && !unlocked && aw_idx == IDX_PER_HI |=> val_w == $past(val_w))
    else $error("period changed while locked");
  enable_on_a: assert property ( // [R1]
    ce && wr_go && w_lane && unlocked && aw_idx == IDX_ENABLE && w_byte[0] && !rel
    |=> pwm_pin_sel) else $error("enable did not take the pin");
  stop_now_a: assert property ( // [R3]
    ce && wr_go && w_lane && unlocked && aw_idx == IDX_ENABLE && !w_byte[0]
    |=> !pwm_pin_sel ##1 (cnt == RST_CNT || !$past(ce)))
    else $error("output not stopped at once");
  release_a: assert property ( // [R4]
    rel |-> !pwm_pin_sel) else $error("released pin still driven");
  irq_gate_a: assert property ( // [R7]
    irq_request |-> flag && ie && gie) else $error("interrupt without enables");
  flag_set_a: assert property ( // [R8]
    ce && wrap |=> flag) else $error("overflow did not set flag");
  flag_hold_a: assert property ( // [R8]
    flag && !(ce && wr_go && aw_idx == IDX_CTRL) |=> flag) else $error("flag lost");
  idle_level_a: assert property ( // [R12]
    ce && !out_en |=> pwm_pin_o == $past(ctl_a.pol)) else $error("idle level wrong");
  zero_period_a: assert property ( // [R14]
    ce && out_en && val_a.period == 12'h000 |=> pwm_pin_o == $past(ctl_a.pol))
    else $error("zero period not at idle level");
  full_duty_a: assert property ( // [R17]
    ce && out_en && val_a.period != 12'h000 && val_a.period <= val_a.duty
    |=> pwm_pin_o != $past(ctl_a.pol)) else $error("full duty not active");
  shadow_hold_a: assert property ( // [R6]
    ce && out_en && !wrap |=> val_a == $past(val_a) && ctl_a == $past(ctl_a))
    else $error("shadow changed mid period");
  low_only_a: assert property ( // [R18]
    ce && wr_go && aw_idx == IDX_PER_LO |=> val_w == $past(val_w))
    else $error("low byte committed alone");
  wrap_zero_a: assert property ( // [R19]
    ce && wrap |=> cnt == RST_CNT) else $error("counter did not wrap");

  wrap_c:    cover property (ce && wrap);
  irq_c:     cover property (irq_request);
  stop_c:    cover property (pwm_pin_sel ##1 !pwm_pin_sel);
  reload_c:  cover property (ce && wrap && val_w != val_a);

endmodule
`default_nettype wire

// [verification/test_twelve_bit_pwm_generator.sv]
`timescale 1ns/1ns
`default_nettype none
module test_twelve_bit_pwm_generator;
  import pwmg_pkg::*;

  // ------------------------------------------------------------
  // Signals and scoreboard
  // ------------------------------------------------------------
  logic        aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, rc_osc_tick, xtal_osc_tick;
  logic        pwm_pin_o, pwm_pin_sel, irq_request;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [1:0]  bq[$];
  logic [33:0] rq[$];
  logic [7:0]  v;
  logic [7:0]  regs[9] = '{IDX_PIN_REL, IDX_ENABLE, IDX_CTRL, IDX_PER_LO, IDX_PER_HI,
                           IDX_DUTY_LO, IDX_DUTY_HI, IDX_LOCK, IDX_SYSCFG};
  logic [3:0]  codes[5] = '{OSC_RC_A, OSC_RC_B, OSC_RC_C, OSC_XTAL, 4'h1};
  int          num_errors, checks_done, hi, t;

  pwmg_top #(.ADDR_W(12)) dut (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .rc_osc_tick, .xtal_osc_tick,
    .pwm_pin_o, .pwm_pin_sel, .irq_request);

  // Clock of 8 ns
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // Crystal ticks arrive at a random rate
  always @(posedge aclk) begin
    xtal_osc_tick <= aresetn ? 1'($urandom_range(1, 0)) : 1'b0;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hang();
    num_errors++;
    $display("BAD %0t bus answer never came", $time);
    stop_test();
  endtask

  // Write one register byte; address and data offered together
  task automatic wr(input logic [7:0] idx, input logic [7:0] val,
                    input logic [1:0] er = RESP_OKAY);
    bit done, aw_take, w_take, b_take;
    done = 0;
    @(posedge aclk);
    awaddr  <= {2'b00, idx, 2'b00};
    wdata   <= {24'h000000, val};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    bq.push_back(er);
    for (int n = 0; n < 100 && !done; n++) begin
      // Handshakes judged on settled levels, then acted on at the edge
      @(negedge aclk);
      aw_take = awvalid && awready;
      w_take  = wvalid && wready;
      b_take  = bvalid && bready;
      @(posedge aclk);
      if (aw_take) awvalid <= 1'b0;
      if (w_take) wvalid <= 1'b0;
      if (b_take) begin
        bready <= 1'b0;
        done = 1;
      end
    end
    if (!done) hang();
  endtask

  // Read one register and note the expected answer
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp,
                    input logic [1:0] er = RESP_OKAY);
    bit done, ar_take, r_take;
    done = 0;
    @(posedge aclk);
    araddr  <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    rq.push_back({er, exp});
    for (int n = 0; n < 100 && !done; n++) begin
      // Handshakes judged on settled levels, then acted on at the edge
      @(negedge aclk);
      ar_take = arvalid && arready;
      r_take  = rvalid && rready;
      @(posedge aclk);
      if (ar_take) arvalid <= 1'b0;
      if (r_take) begin
        rready <= 1'b0;
        done = 1;
      end
    end
    if (!done) hang();
  endtask

  // Count cycles with the pin level high
  task automatic cnt(input int n);
    hi = 0;
    repeat (n) begin
      @(negedge aclk);
      if (pwm_pin_o === 1'b1) hi++;
    end
  endtask

  // Response watcher compares against the oldest note, on settled levels
  always @(negedge aclk) begin
    if (bvalid && bready && bq.size() > 0) begin
      chk({32'h0, bresp}, {32'h0, bq.pop_front()});
    end
    if (rvalid && rready && rq.size() > 0) begin
      chk({rresp, rdata}, rq.pop_front());
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {ce, rc_osc_tick, wstrb} = {1'b1, 1'b1, 4'hf};
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, xtal_osc_tick} = '0;
    num_errors = 0;
    checks_done = 0;
    void'($urandom(32'h11ada943));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (regs[i]) rd(regs[i], 32'h0);
    rd(8'h00, 32'h0, RESP_SLV);
    wr(8'h00, 8'hff, RESP_SLV);
    chk({pwm_pin_sel, pwm_pin_o, irq_request}, 3'b000);
    $display("reset test done");
    v = 8'($urandom_range(255, 1));
    if (v == LOCK_KEY) v = 8'h5a;
    wr(IDX_LOCK, v);
    for (int i = 1; i < 7; i++) begin
      wr(regs[i], v);
      rd(regs[i], 32'h0);
    end
    rd(IDX_LOCK, {24'h0, v});
    $display("lock test done");
    wr(IDX_LOCK, LOCK_KEY);
    wr(IDX_PER_LO, 8'h05);
    rd(IDX_PER_LO, 32'h05);
    wr(IDX_PER_HI, 8'h00);
    wr(IDX_DUTY_LO, 8'h02);
    wr(IDX_DUTY_HI, 8'h00);
    wr(IDX_ENABLE, 8'h01);
    rd(IDX_ENABLE, 32'h01);
    chk(pwm_pin_sel, 1'b1);
    for (int i = 0; i < 8; i++) begin
      t = 2 << (i % 4);
      wr(IDX_CTRL, 8'(i));
      repeat (90 + 10 * t) @(posedge aclk);
      cnt(20 * t);
      chk(hi, i > 3 ? 12 * t : 8 * t);
    end
    $display("waveform test done");
    wr(IDX_SYSCFG, 8'h80);
    wr(IDX_CTRL, 8'h80);
    repeat (100) @(posedge aclk);
    chk(irq_request, 1'b1);
    wr(IDX_SYSCFG, 8'h00);
    chk(irq_request, 1'b0);
    wr(IDX_CTRL, 8'h00);
    wr(IDX_ENABLE, 8'h00);
    chk(pwm_pin_sel, 1'b0);
    repeat (3) @(posedge aclk);
    chk(pwm_pin_o, 1'b0);
    wr(IDX_CTRL, 8'h04);
    repeat (3) @(posedge aclk);
    chk(pwm_pin_o, 1'b1);
    wr(IDX_CTRL, 8'h00);
    wr(IDX_ENABLE, 8'h01);
    $display("interrupt and stop test done");
    wr(IDX_PIN_REL, 8'h01);
    chk(pwm_pin_sel, 1'b0);
    foreach (codes[i]) begin
      wr(IDX_SYSCFG, {4'h0, codes[i]});
      if (i == 4) rd(IDX_CTRL, 32'h40);
      wr(IDX_CTRL, 8'h00);
      repeat (200) @(posedge aclk);
      rd(IDX_CTRL, i < 4 ? 32'h40 : 32'h00);
    end
    wr(IDX_SYSCFG, 8'h00);
    wr(IDX_PIN_REL, 8'h00);
    chk(pwm_pin_sel, 1'b1);
    $display("release and source test done");
    wr(IDX_DUTY_LO, 8'h05);
    repeat (40) @(posedge aclk);
    cnt(40);
    chk(hi, 16);
    wr(IDX_DUTY_HI, 8'h00);
    repeat (40) @(posedge aclk);
    cnt(40);
    chk(hi, 40);
    wr(IDX_PER_LO, 8'h00);
    wr(IDX_PER_HI, 8'h00);
    repeat (40) @(posedge aclk);
    cnt(40);
    chk(hi, 0);
    wr(IDX_ENABLE, 8'h00);
    wr(IDX_CTRL, 8'h04);
    wr(IDX_ENABLE, 8'h01);
    repeat (20) @(posedge aclk);
    cnt(40);
    chk(hi, 40);
    $display("limit test done");
    wr(IDX_LOCK, 8'h00);
    wr(IDX_ENABLE, 8'h00);
    chk(pwm_pin_sel, 1'b1);
    $display("relock test done");
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(IDX_LOCK, 32'h0);
    wr(IDX_ENABLE, 8'h01);
    rd(IDX_ENABLE, 32'h0);
    chk({pwm_pin_sel, irq_request}, 2'b00);
    $display("second reset test done");
    stop_test();
  end

endmodule
`default_nettype wire
